// >>> src/lu_consts.vh
`ifndef LU_CONSTS_VH
`define LU_CONSTS_VH

// apb byte addresses
`define ADDR_RECEIVE_CONTROL 8'h00
`define ADDR_CHANNEL_CONTROL 8'h04
`define ADDR_ERROR_COUNT     8'h08
`define ADDR_IRQ_STATUS      8'h0C
`define ADDR_IRQ_MASK        8'h10
`define ADDR_LINE_STATUS     8'h14

// receive_control fields
`define RC_EQUALIZER_BIT     0
`define RC_MONITOR_BIT       1
`define RC_MUTE_BIT          2
`define RC_WIDTH             6
`define RC_RESET             6'h00

// channel_control fields
`define CC_RAIL_BIT          0
`define CC_STS1_BIT          1
`define CC_E3_BIT            2
`define CC_LOCAL_LB_BIT      3
`define CC_REMOTE_LB_BIT     4
`define CC_PRBS_BIT          5
`define CC_WIDTH             6
`define CC_RESET             6'h00

// interrupt status / mask layout
`define IRQ_PATTERN_ERR_BIT  0
`define IRQ_SIGNAL_LOSS_BIT  1
`define IRQ_LOCK_BIT         2
`define IRQ_WIDTH            3
`define IRQ_RESET            3'h0

// loopback mode codes on loopback_mode_out
`define LB_NORMAL            2'h0
`define LB_REMOTE            2'h1
`define LB_ANALOG_LOCAL      2'h2
`define LB_DIGITAL_LOCAL     2'h3

// pattern engine
`define PRBS_LEN_SHORT       15
`define PRBS_LEN_LONG        23
`define PRBS_SHORT_TAP       14
`define PRBS_LONG_TAP        18
`define PRBS_SEED            23'h7F_FFFF
`define SYNC_GOOD_BITS       6'h20
`define ERR_COUNT_WIDTH      16
`define ERR_COUNT_MAX        16'hFFFF

`endif

// >>> src/prbs_lfsr.v
`default_nettype none

module prbs_lfsr (
    input  wire        clock_in,     // system clock
    input  wire        rst_n_in,     // async reset, active low
    input  wire        step_in,      // advance one bit
    input  wire        restart_in,   // reload seed
    input  wire        long_in,      // 1: 2^23-1, 0: 2^15-1
    input  wire        check_in,     // 1: shift in data_in (checker form)
    input  wire        data_in,      // received bit in checker form
    output wire        bit_out       // generated or predicted bit
);

`include "lu_consts.vh"

    reg  [22:0] state_reg;

    function fb;
        input [22:0] s;
        input        long_sel;
        begin
            if (long_sel) begin
                fb = s[`PRBS_LEN_LONG-1] ^ s[`PRBS_LONG_TAP-1];
            end else begin
                fb = s[`PRBS_LEN_SHORT-1] ^ s[`PRBS_SHORT_TAP-1];
            end
        end
    endfunction

    assign bit_out = fb(state_reg, long_in);

    // checker form reseeds itself from the line, so it finds the pattern at any phase
    always @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg <= `PRBS_SEED;
        end else if (restart_in) begin
            state_reg <= `PRBS_SEED;
        end else if (step_in) begin
            state_reg <= {state_reg[21:0], check_in ? data_in : bit_out};
        end
    end

endmodule

`default_nettype wire

// >>> src/lu_rx_control_prbs_diag.v
// Our own choices: the address map and the APB slave port.
`default_nettype none

// Behaviour
// - with mute enabled, both recovered data outputs are held low while loss of signal is declared.
// - monitor mode suppresses loss of signal so it is never declared.
// - the equalizer enable bit drives the receive equalizer on when 1 and off when 0.
// - the prbs enable bit switches generator and checker on and off together.
// - in DS3 or STS-1 rate the generator sends an unframed 2^15-1 sequence.
// - in E3 rate the generator sends an unframed 2^23-1 sequence.
// - the checker searches the recovered data for the sequence of the configured rate.
// - while prbs is on, dual-rail form is overridden and single-rail form is used.
// - during prbs the negative rail/violation output flags each detected bit error.
// - during prbs each detected bit error is added to the 16 bit saturating error counter.
// - during prbs the transmit data inputs are ignored and the pattern is sent instead.
// - local and remote loopback bits select normal, remote, analog local or digital local.
// - the E3 bit selects E3 rate, otherwise the rate bit picks DS3 or STS-1.
module lu_rx_control_prbs_diag (
    input  wire        clock_in,                     // 40 MHz system clock
    input  wire        rst_n_in,                     // async reset, active low
    input  wire        psel_in,                      // apb select
    input  wire        penable_in,                   // apb enable
    input  wire        pwrite_in,                    // apb direction
    input  wire [7:0]  paddr_in,                     // apb byte address
    input  wire [31:0] pwdata_in,                    // apb write data
    output reg  [31:0] prdata_out,                   // apb read data
    output reg         pready_out,                   // apb ready
    output reg         pslverr_out,                  // apb error, unmapped address
    input  wire        transmit_clock_input_in,      // framer transmit clock
    input  wire        transmit_data_positive_in,    // framer transmit data, positive rail
    input  wire        transmit_data_negative_in,    // framer transmit data, negative rail
    input  wire        recovered_clock_in,           // recovered receive clock
    input  wire        line_rx_positive_in,          // recovered data from decoder, positive
    input  wire        line_rx_negative_in,          // recovered data from decoder, negative
    input  wire        line_code_violation_in,       // code violation from decoder
    input  wire        raw_signal_loss_in,           // loss of signal from detector
    output reg         line_tx_positive_out,         // data to line encoder, positive
    output reg         line_tx_negative_out,         // data to line encoder, negative
    output reg         recovered_data_positive_out,  // recovered data to framer, positive
    output reg         recovered_data_negative_out,  // recovered data to framer, negative
    output reg         negative_rail_violation_out,  // negative rail, violation or pattern error
    output reg         signal_loss_out,              // declared loss of signal
    output reg         equalizer_enable_out,         // receive equalizer on
    output reg  [1:0]  loopback_mode_out,            // loopback mode code
    output reg         european_rate_out,            // E3 rate selected
    output reg         sonet_rate_out,               // STS-1 rate selected (when not E3)
    output reg         single_rail_out,              // system interface in single-rail form
    output reg         irq_out                       // level interrupt
);

`include "lu_consts.vh"

    reg  [`RC_WIDTH-1:0]        receive_control_reg;
    reg  [`CC_WIDTH-1:0]        channel_control_reg;
    reg  [`ERR_COUNT_WIDTH-1:0] error_count_reg;
    reg  [`IRQ_WIDTH-1:0]       irq_status_reg;
    reg  [`IRQ_WIDTH-1:0]       irq_status_next;
    reg  [`IRQ_WIDTH-1:0]       irq_mask_reg;
    reg                         prbs_enable_d_reg;
    reg  [5:0]                  good_bits_reg;
    reg                         locked_reg;
    reg                         signal_loss_d_reg;

    // two-stage synchronisers: stage 1 is read only by stage 2
    reg  [2:0]                  tx_meta_reg;
    reg  [2:0]                  tx_sync_reg;
    reg                         tx_clk_d_reg;
    reg  [4:0]                  rx_meta_reg;
    reg  [4:0]                  rx_sync_reg;
    reg                         rx_clk_d_reg;

    wire                        access;
    wire                        wr;
    wire                        mapped;
    wire                        prbs_on;
    wire                        prbs_restart;
    wire                        long_pattern;
    wire                        tx_edge;
    wire                        rx_edge;
    wire                        loss_now;
    wire                        gen_bit;
    wire                        chk_bit;
    wire                        pattern_err;
    wire                        dual_rail;

    function is_mapped;
        input [7:0] a;
        begin
            is_mapped = (a == `ADDR_RECEIVE_CONTROL) || (a == `ADDR_CHANNEL_CONTROL) ||
                        (a == `ADDR_ERROR_COUNT)     || (a == `ADDR_IRQ_STATUS)      ||
                        (a == `ADDR_IRQ_MASK)        || (a == `ADDR_LINE_STATUS);
        end
    endfunction

    // one wait state, so read data can come from a register
    assign access       = psel_in & penable_in & pready_out;
    assign mapped       = is_mapped(paddr_in);
    assign wr           = access & pwrite_in & mapped;

    assign prbs_on      = channel_control_reg[`CC_PRBS_BIT];
    assign prbs_restart = prbs_on & ~prbs_enable_d_reg;
    assign long_pattern = channel_control_reg[`CC_E3_BIT];
    assign dual_rail    = ~channel_control_reg[`CC_RAIL_BIT] & ~prbs_on;

    assign tx_edge      = tx_sync_reg[0] & ~tx_clk_d_reg;
    assign rx_edge      = rx_sync_reg[0] & ~rx_clk_d_reg;

    // monitor mode masks the detector entirely
    assign loss_now     = rx_sync_reg[4] & ~receive_control_reg[`RC_MONITOR_BIT];

    // errors count only after the checker has found the sequence
    assign pattern_err  = prbs_on & locked_reg & rx_edge & (rx_sync_reg[1] != chk_bit);

    prbs_lfsr u_prbs_lfsr_tx (
        .clock_in   (clock_in),
        .rst_n_in   (rst_n_in),
        .step_in    (prbs_on & tx_edge),
        .restart_in (prbs_restart),
        .long_in    (long_pattern),
        .check_in   (1'b0),
        .data_in    (1'b0),
        .bit_out    (gen_bit)
    );

    prbs_lfsr u_prbs_lfsr_rx (
        .clock_in   (clock_in),
        .rst_n_in   (rst_n_in),
        .step_in    (prbs_on & rx_edge),
        .restart_in (prbs_restart),
        .long_in    (long_pattern),
        .check_in   (1'b1),
        .data_in    (rx_sync_reg[1]),
        .bit_out    (chk_bit)
    );

    always @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_meta_reg  <= 3'h0;
            tx_sync_reg  <= 3'h0;
            tx_clk_d_reg <= 1'b0;
            rx_meta_reg  <= 5'h00;
            rx_sync_reg  <= 5'h00;
            rx_clk_d_reg <= 1'b0;
        end else begin
            tx_meta_reg  <= {transmit_data_negative_in, transmit_data_positive_in,
                             transmit_clock_input_in};
            tx_sync_reg  <= tx_meta_reg;
            tx_clk_d_reg <= tx_sync_reg[0];
            rx_meta_reg  <= {raw_signal_loss_in, line_code_violation_in, line_rx_negative_in,
                             line_rx_positive_in, recovered_clock_in};
            rx_sync_reg  <= rx_meta_reg;
            rx_clk_d_reg <= rx_sync_reg[0];
        end
    end

    // apb slave and register file
    always @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pready_out          <= 1'b0;
            pslverr_out         <= 1'b0;
            prdata_out          <= 32'h0000_0000;
            receive_control_reg <= `RC_RESET;
            channel_control_reg <= `CC_RESET;
            irq_mask_reg        <= `IRQ_RESET;
        end else begin
            pready_out  <= psel_in & penable_in & ~pready_out;
            pslverr_out <= psel_in & penable_in & ~pready_out & ~mapped;
            prdata_out  <= 32'h0000_0000;
            if (psel_in & penable_in & ~pready_out & ~pwrite_in) begin
                case (paddr_in)
                    `ADDR_RECEIVE_CONTROL: prdata_out <= {26'h000_0000, receive_control_reg};
                    `ADDR_CHANNEL_CONTROL: prdata_out <= {26'h000_0000, channel_control_reg};
                    `ADDR_ERROR_COUNT:     prdata_out <= {16'h0000, error_count_reg};
                    `ADDR_IRQ_STATUS:      prdata_out <= {29'h0000_0000, irq_status_reg};
                    `ADDR_IRQ_MASK:        prdata_out <= {29'h0000_0000, irq_mask_reg};
                    `ADDR_LINE_STATUS:     prdata_out <= {30'h0000_0000, locked_reg,
                                                          signal_loss_out};
                    default:               prdata_out <= 32'h0000_0000;
                endcase
            end
            if (wr && paddr_in == `ADDR_RECEIVE_CONTROL) begin
                receive_control_reg <= pwdata_in[`RC_WIDTH-1:0];
            end
            if (wr && paddr_in == `ADDR_CHANNEL_CONTROL) begin
                channel_control_reg <= pwdata_in[`CC_WIDTH-1:0];
            end
            if (wr && paddr_in == `ADDR_IRQ_MASK) begin
                irq_mask_reg <= pwdata_in[`IRQ_WIDTH-1:0];
            end
        end
    end

    // sticky events: a new event wins over a same-cycle write-one clear
    always @* begin
        irq_status_next = irq_status_reg;
        if (wr && paddr_in == `ADDR_IRQ_STATUS) begin
            irq_status_next = irq_status_reg & ~pwdata_in[`IRQ_WIDTH-1:0];
        end
        irq_status_next[`IRQ_PATTERN_ERR_BIT] = irq_status_next[`IRQ_PATTERN_ERR_BIT] |
                                                pattern_err;
        irq_status_next[`IRQ_SIGNAL_LOSS_BIT] = irq_status_next[`IRQ_SIGNAL_LOSS_BIT] |
                                                (loss_now & ~signal_loss_d_reg);
        irq_status_next[`IRQ_LOCK_BIT]        = irq_status_next[`IRQ_LOCK_BIT] |
                                                (prbs_on & rx_edge & ~locked_reg &
                                                 (good_bits_reg == `SYNC_GOOD_BITS - 6'h01) &
                                                 (rx_sync_reg[1] == chk_bit));
    end

    // pattern search, error counter and interrupts
    always @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_status_reg    <= `IRQ_RESET;
            irq_out           <= 1'b0;
            prbs_enable_d_reg <= 1'b0;
            good_bits_reg     <= 6'h00;
            locked_reg        <= 1'b0;
            signal_loss_d_reg <= 1'b0;
            error_count_reg   <= 16'h0000;
        end else begin
            irq_status_reg    <= irq_status_next;
            irq_out           <= |(irq_status_next & irq_mask_reg);
            prbs_enable_d_reg <= prbs_on;
            signal_loss_d_reg <= loss_now;
            if (!prbs_on || prbs_restart) begin
                good_bits_reg <= 6'h00;
                locked_reg    <= 1'b0;
            end else if (rx_edge && !locked_reg) begin
                if (rx_sync_reg[1] != chk_bit) begin
                    good_bits_reg <= 6'h00;
                end else if (good_bits_reg == `SYNC_GOOD_BITS - 6'h01) begin
                    locked_reg <= 1'b1;
                end else begin
                    good_bits_reg <= good_bits_reg + 6'h01;
                end
            end
            // a write clears the counter; a count in that cycle still lands, saturating
            if (wr && paddr_in == `ADDR_ERROR_COUNT) begin
                error_count_reg <= {15'h0000, pattern_err};
            end else if (pattern_err && error_count_reg != `ERR_COUNT_MAX) begin
                error_count_reg <= error_count_reg + 16'h0001;
            end
        end
    end

    // line-facing outputs and decoded control
    always @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            line_tx_positive_out        <= 1'b0;
            line_tx_negative_out        <= 1'b0;
            recovered_data_positive_out <= 1'b0;
            recovered_data_negative_out <= 1'b0;
            negative_rail_violation_out <= 1'b0;
            signal_loss_out             <= 1'b0;
            equalizer_enable_out        <= 1'b0;
            loopback_mode_out           <= `LB_NORMAL;
            european_rate_out           <= 1'b0;
            sonet_rate_out              <= 1'b0;
            single_rail_out             <= 1'b1;
        end else begin
            signal_loss_out      <= loss_now;
            equalizer_enable_out <= receive_control_reg[`RC_EQUALIZER_BIT];
            european_rate_out    <= channel_control_reg[`CC_E3_BIT];
            sonet_rate_out       <= channel_control_reg[`CC_STS1_BIT];
            single_rail_out      <= ~dual_rail;
            case ({channel_control_reg[`CC_LOCAL_LB_BIT],
                   channel_control_reg[`CC_REMOTE_LB_BIT]})
                2'b01:   loopback_mode_out <= `LB_REMOTE;
                2'b10:   loopback_mode_out <= `LB_ANALOG_LOCAL;
                2'b11:   loopback_mode_out <= `LB_DIGITAL_LOCAL;
                default: loopback_mode_out <= `LB_NORMAL;
            endcase
            if (tx_edge) begin
                if (prbs_on) begin
                    // framer data dropped; pattern is single-rail on the positive line
                    line_tx_positive_out <= gen_bit;
                    line_tx_negative_out <= 1'b0;
                end else begin
                    line_tx_positive_out <= tx_sync_reg[1];
                    line_tx_negative_out <= dual_rail & tx_sync_reg[2];
                end
            end
            if (loss_now && receive_control_reg[`RC_MUTE_BIT]) begin
                recovered_data_positive_out <= 1'b0;
                recovered_data_negative_out <= 1'b0;
            end else if (rx_edge) begin
                recovered_data_positive_out <= rx_sync_reg[1];
                recovered_data_negative_out <= dual_rail & rx_sync_reg[2];
            end
            // error pulse lasts one system cycle per errored bit
            if (prbs_on) begin
                negative_rail_violation_out <= pattern_err;
            end else if (dual_rail) begin
                negative_rail_violation_out <= (loss_now & receive_control_reg[`RC_MUTE_BIT]) ?
                                               1'b0 : rx_sync_reg[2];
            end else begin
                negative_rail_violation_out <= rx_sync_reg[3];
            end
        end
    end

endmodule

`default_nettype wire

// >>> dv/lu_diag_checker.sv
`default_nettype none
`include "lu_consts.vh"
module lu_diag_checker (
    input wire logic        clock_in,             // clock
    input wire logic        rst_n_in,             // reset
    input wire logic        psel_in,              // select
    input wire logic        penable_in,           // enable
    input wire logic        pwrite_in,            // direction
    input wire logic [7:0]  paddr_in,             // address
    input wire logic [31:0] pwdata_in,            // write data
    input wire logic [31:0] prdata_out,           // read data
    input wire logic        pready_out,           // ready
    input wire logic        pslverr_out,          // error
    input wire logic        raw_signal_loss_in,   // raw loss
    input wire logic        signal_loss_out,      // declared loss
    input wire logic        equalizer_enable_out, // equalizer
    input wire logic [1:0]  loopback_mode_out,    // loop mode
    input wire logic        european_rate_out,    // e3 rate
    input wire logic        sonet_rate_out,       // sts-1 rate
    input wire logic        single_rail_out       // single rail
);
    timeunit 1ns;
    timeprecision 1ps;
    wire wr_done = psel_in && penable_in && pready_out && pwrite_in;
    wire wr_rc   = wr_done && paddr_in == `ADDR_RECEIVE_CONTROL;
    wire wr_cc   = wr_done && paddr_in == `ADDR_CHANNEL_CONTROL;
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_n_in);
    sequence s_setup;
        psel_in && !penable_in;
    endsequence
    sequence s_access;
        psel_in && penable_in;
    endsequence
    a_apb_wait_state: assert property (s_setup ##1 s_access |-> !pready_out ##1 pready_out)
        else $error("ready not after one wait state");
    a_ready_one_cycle: assert property (pready_out |=> !pready_out)
        else $error("ready held longer than one cycle");
    a_rdata_idle_zero: assert property (!pready_out |-> prdata_out == 32'h0000_0000)
        else $error("read data not zero outside access");
    a_unmapped_err: assert property (pready_out && paddr_in > `ADDR_LINE_STATUS
        |-> pslverr_out && prdata_out == 32'h0000_0000) else $error("unmapped access accepted");
    a_eq_follows: assert property (wr_rc |-> ##2 equalizer_enable_out == $past(pwdata_in[0], 2))
        else $error("equalizer enable wrong after write");
    a_rate_follows: assert property (wr_cc |-> ##2 european_rate_out == $past(pwdata_in[2], 2)
        && sonet_rate_out == $past(pwdata_in[1], 2)) else $error("rate select wrong after write");
    a_loop_follows: assert property (wr_cc |-> ##2 loopback_mode_out
        == {$past(pwdata_in[3], 2), $past(pwdata_in[4], 2)}) else $error("loopback mode wrong");
    a_rail_forced: assert property (wr_cc |-> ##2 single_rail_out
        == ($past(pwdata_in[0], 2) | $past(pwdata_in[5], 2))) else $error("rail form wrong");
    a_loss_cause: assert property ($rose(signal_loss_out) |-> $past(raw_signal_loss_in, 2))
        else $error("loss declared without raw loss");
endmodule
`default_nettype wire

// >>> dv/framer_model.sv
`default_nettype none
module framer_model (
    input  wire logic line_tx_in,   // bit sent toward line
    input  wire logic flip_in,      // corrupt looped data
    output var  logic tx_clock_out, // transmit clock
    output var  logic tx_pos_out,   // transmit data
    output var  logic tx_neg_out,   // transmit data, negative
    output var  logic rx_clock_out, // recovered clock
    output var  logic rx_pos_out,   // recovered data
    output var  logic rx_neg_out    // recovered data, negative
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] phase = 3'h0;
    // odd start offset keeps the line clock out of phase with the system clock
    initial begin
        tx_clock_out = 1'b0;
        #37ns;
        forever #100ns tx_clock_out = ~tx_clock_out;
    end
    always @(negedge tx_clock_out) phase <= phase + 3'h1;
    assign tx_pos_out   = phase[2] ^ phase[0];
    assign tx_neg_out   = ~tx_pos_out;
    assign rx_clock_out = tx_clock_out;
    assign rx_pos_out   = line_tx_in ^ flip_in;
    assign rx_neg_out   = 1'b0;
endmodule
`default_nettype wire

// >>> dv/test_lu_rx_control_prbs_diag.sv
`default_nettype none
`include "lu_consts.vh"
module test_lu_rx_control_prbs_diag;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic        psel_in = 1'b0;
    logic        penable_in = 1'b0;
    logic        pwrite_in = 1'b0;
    logic [7:0]  paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0000_0000;
    logic        raw_signal_loss_in = 1'b0;
    logic        line_code_violation_in = 1'b0;
    logic        flip = 1'b0;
    logic        cap = 1'b0;
    logic        last_err;
    logic [31:0] last_data;
    logic        bits[$];
    int          n_errors = 0;
    int          compares = 0;
    int          cycles = 0;
    int          pulses = 0;
    int          ones;
    wire         transmit_clock_input_in, transmit_data_positive_in, transmit_data_negative_in;
    wire         recovered_clock_in, line_rx_positive_in, line_rx_negative_in;
    wire  [31:0] prdata_out;
    wire  [1:0]  loopback_mode_out;
    wire         pready_out, pslverr_out, line_tx_positive_out, line_tx_negative_out;
    wire         recovered_data_positive_out, recovered_data_negative_out, irq_out;
    wire         negative_rail_violation_out, signal_loss_out, equalizer_enable_out;
    wire         european_rate_out, sonet_rate_out, single_rail_out;
    lu_rx_control_prbs_diag u_lu_rx_control_prbs_diag (.*);
    framer_model u_framer_model (.line_tx_in(line_tx_positive_out), .flip_in(flip),
        .tx_clock_out(transmit_clock_input_in), .tx_pos_out(transmit_data_positive_in),
        .tx_neg_out(transmit_data_negative_in), .rx_clock_out(recovered_clock_in),
        .rx_pos_out(line_rx_positive_in), .rx_neg_out(line_rx_negative_in));
    always #12.5ns clock_in = ~clock_in;
    always @(posedge clock_in) begin
        cycles++;
        pulses += negative_rail_violation_out;
        if (cycles == 20000) begin
            n_errors++;
            finish_test();
        end
    end
    always @(posedge transmit_clock_input_in) if (cap) bits.push_back(line_tx_positive_out);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one idle edge first, so back-to-back calls never drive psel twice at once
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clock_in);
        penable_in <= 1'b1;
        do @(posedge clock_in); while (pready_out !== 1'b1);
        last_data = prdata_out;
        last_err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(last_data, exp);
    endtask
    task automatic count_rx();
        ones = 0;
        repeat (80) @(posedge clock_in) ones += recovered_data_positive_out;
    endtask
    task automatic prbs_run(input logic [31:0] cc, input int len, input int tap);
        int bad;
        bad = 0;
        ones = 0;
        wr(`ADDR_CHANNEL_CONTROL, cc);
        repeat (80) @(posedge transmit_clock_input_in);
        bits.delete();
        cap = 1'b1;
        repeat (60) @(posedge transmit_clock_input_in);
        cap = 1'b0;
        for (int n = len; n < bits.size(); n++) begin
            bad += (bits[n] !== (bits[n - len] ^ bits[n - tap]));
            ones += bits[n];
        end
        check(bad, 0);
        check(ones != 0, 1);
        check(line_tx_negative_out, 0);
        check(single_rail_out, 1);
        rd(`ADDR_LINE_STATUS, 32'h0000_0002);
        wr(`ADDR_ERROR_COUNT, 32'h0000_0000);
        pulses = 0;
        @(negedge transmit_clock_input_in) flip = 1'b1;
        @(negedge transmit_clock_input_in) flip = 1'b0;
        repeat (40) @(posedge transmit_clock_input_in);
        check(pulses, 3);
        rd(`ADDR_ERROR_COUNT, 32'h0000_0003);
        rd(`ADDR_IRQ_STATUS, 32'h0000_0005);
        wr(`ADDR_IRQ_STATUS, 32'h0000_0007);
        wr(`ADDR_CHANNEL_CONTROL, 32'h0000_0000);
        repeat (3) @(posedge clock_in);
        check(single_rail_out, 0);
    endtask
    task automatic finish_test();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clock_in);
        rst_n_in <= 1'b1;
        for (int a = 0; a <= 8'h14; a += 4) rd(8'(a), 32'h0000_0000);
        rd(8'h40, 32'h0000_0000);
        check(last_err, 1);
        wr(`ADDR_RECEIVE_CONTROL, 32'hFFFF_FFFF);
        rd(`ADDR_RECEIVE_CONTROL, 32'h0000_003F);
        check(equalizer_enable_out, 1);
        wr(`ADDR_RECEIVE_CONTROL, 32'h0000_0000);
        repeat (3) @(posedge clock_in);
        check(equalizer_enable_out, 0);
        for (int i = 0; i < 4; i++) begin
            wr(`ADDR_CHANNEL_CONTROL, {27'h0, i[0], i[1], i[0], i[1], 1'b1});
            repeat (3) @(posedge clock_in);
            check(loopback_mode_out, i[1:0]);
            check({european_rate_out, sonet_rate_out}, {i[0], i[1]});
        end
        wr(`ADDR_CHANNEL_CONTROL, 32'hFFFF_FFDF);
        rd(`ADDR_CHANNEL_CONTROL, 32'h0000_001F);
        wr(`ADDR_CHANNEL_CONTROL, 32'h0000_0000);
        wr(`ADDR_RECEIVE_CONTROL, 32'h0000_0005);
        raw_signal_loss_in <= 1'b1;
        repeat (8) @(posedge clock_in);
        check(signal_loss_out, 1);
        check(irq_out, 0);
        count_rx();
        check(ones, 0);
        wr(`ADDR_IRQ_MASK, 32'h0000_0002);
        repeat (3) @(posedge clock_in);
        check(irq_out, 1);
        wr(`ADDR_IRQ_STATUS, 32'h0000_0002);
        repeat (3) @(posedge clock_in);
        check(irq_out, 0);
        wr(`ADDR_RECEIVE_CONTROL, 32'h0000_0001);
        count_rx();
        check(ones != 0, 1);
        wr(`ADDR_RECEIVE_CONTROL, 32'h0000_0003);
        repeat (8) @(posedge clock_in);
        check(signal_loss_out, 0);
        raw_signal_loss_in <= 1'b0;
        wr(`ADDR_RECEIVE_CONTROL, 32'h0000_0001);
        prbs_run(32'h0000_0020, 15, 14);
        prbs_run(32'h0000_0022, 15, 14);
        prbs_run(32'h0000_0024, 23, 18);
        finish_test();
    end
endmodule
bind lu_rx_control_prbs_diag lu_diag_checker u_lu_diag_checker (.*);
`default_nettype wire
